// file: design/ads_self_check_result_seq.sv
// diagnostic sequencer: self-check selections, switch checks, APB regs
// How it works
// R1 - offset check selection shorts amplifier inputs during diagnostic phase.
// R2 - selected check measurement lands in result register at acquisition end.
// R3 - offset check forces bipolar polarity whatever the configured setting.
// R4 - offset check skips the chopping phase, keeping offset in the result.
// R5 - result is a 14-bit code in bits 15:2, centred on 2000h.
// R6 - zero-scale selection drives converter to negative supply, bipolar.
// R7 - full-scale selection drives converter to positive supply, bipolar.
// R8 - mode codes: short 001, open 010, odd wire 101, even wire 110.
// R9 - any mode reconfigures acquisition, alternate path, compares and flags.
// R10 - host starts every acquisition; device only configures and evaluates.
// R11 - active mode suppresses over-voltage, under-voltage, mismatch alerts.
// R12 - clearing the mode restores all automatically altered settings.
// R13 - short mode: switches off, aux/block measure off, alternate path.
// R14 - short mode flags a channel whose switch voltage is below threshold.
// R15 - open mode: bipolar, alternate path, measure enabled switches only.
// R16 - open mode flags voltage above high or below low threshold.
// R17 - host preloads short, low and high thresholds before a check.
// R18 - host keeps short threshold near minimum cell minus 100mV.
// R19 - wire-open modes close odd or even switches and compare limits.
// R20 - host waits 100us after wire-open mode entry before starting.
// R21 - one flag per channel, held until software clears it.
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
module ads_self_check_result_seq
    import ads_pkg::*;
#(
    parameter int CellCount = ADS_NCELL
) (
    input wire logic mclk, // 20 MHz clock
    input wire logic nrst, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire ads_smp_t smp, // converter result stream
    input wire logic diagPhase, // diagnostic portion of acquisition
    input wire logic acqDone, // acquisition finished pulse
    input wire logic [2:0] limitHits, // ov, uv, mismatch comparator hits
    output ads_eff_t eff, // effective acquisition configuration
    output logic [11:0] swAlert, // switch alert flags
    output logic [2:0] limitAlert // ov, uv, mismatch alert flags
);
    if (CellCount != ADS_NCELL) begin : g_chk
        $error("cell count must match the register layout");
    end

    typedef struct packed {
        ads_cfg_t cfg;
        ads_eff_t eff;
        logic [15:0] thrShort;
        logic [15:0] thrLow;
        logic [15:0] thrHigh;
        logic [15:0] pend;
        logic [15:0] result;
        logic [11:0] swFlags;
        logic [2:0] alerts;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ads_state_t;

    ads_state_t r;
    ads_state_t n;
    logic access;
    logic wr;
    logic mapped;
    logic [31:0] rd;
    logic [11:0] swSet;
    logic swWr;
    logic [15:0] code;

    assign access = psel & penable;
    assign wr = access & r.pready & pwrite;
    assign swWr = wr & (paddr == OFS_SWFLAGS);
    // only the 14 significant bits are kept, low bits read zero
    assign code = {smp.data[15:2], 2'b00}; // [R5]

    always_comb begin
        mapped = 1'b1;
        rd = 32'h0000_0000;
        case (paddr)
            OFS_CTRL: begin
                rd[CTRL_SEL_LSB +: 3] = r.cfg.checkSel;
                rd[CTRL_MODE_LSB +: 3] = r.cfg.mode;
                rd[CTRL_BIPOLAR] = r.cfg.bipolar;
                rd[CTRL_ALTPATH] = r.cfg.altPath;
            end
            OFS_BALEN: rd[11:0] = r.cfg.balEn;
            OFS_MEASEN: rd[14:0] = r.cfg.measEn;
            OFS_THR_SHORT: rd[15:0] = r.thrShort;
            OFS_THR_LOW: rd[15:0] = r.thrLow;
            OFS_THR_HIGH: rd[15:0] = r.thrHigh;
            OFS_RESULT: rd[15:0] = r.result;
            OFS_SWFLAGS: rd[11:0] = r.swFlags;
            OFS_ALERTS: rd[2:0] = r.alerts;
            OFS_EFFCFG: begin
                rd[11:0] = r.eff.balEn;
                rd[EFF_BIPOLAR] = r.eff.bipolar;
                rd[EFF_ALTPATH] = r.eff.altPath;
                rd[EFF_MEAS_LSB +: 15] = r.eff.measEn;
            end
            default: mapped = 1'b0;
        endcase
    end

    // per-channel threshold compare, only on cell samples in a mode
    always_comb begin
        swSet = 12'h000;
        if (smp.valid && !smp.self_check_result && smp.idx < 4'hC) begin
            case (r.cfg.mode)
                MODE_SHORT: begin
                    swSet[smp.idx] = smp.data < r.thrShort; // [R14]
                end
                MODE_OPEN, MODE_ODD, MODE_EVEN: begin
                    // unmeasured positions never flag
                    swSet[smp.idx] = r.eff.measEn[smp.idx] &
                        (smp.data > r.thrHigh |
                        smp.data < r.thrLow); // [R16] [R19]
                end
                default: swSet = 12'h000;
            endcase
        end
    end

    always_comb begin
        n = r;
        n.eff.acqStart = 1'b0;
        // answer one cycle into access; write lands on the completing edge
        n.pready = access & !r.pready;
        n.pslverr = access & !r.pready & !mapped;
        if (access && !r.pready) begin
            n.prdata = pwrite ? 32'h0000_0000 : rd;
        end
        if (wr) begin
            case (paddr)
                OFS_CTRL: begin
                    n.cfg.checkSel = pwdata[CTRL_SEL_LSB +: 3];
                    n.cfg.mode = pwdata[CTRL_MODE_LSB +: 3];
                    n.cfg.bipolar = pwdata[CTRL_BIPOLAR];
                    n.cfg.altPath = pwdata[CTRL_ALTPATH];
                    n.eff.acqStart = pwdata[CTRL_START]; // [R10]
                end
                OFS_BALEN: n.cfg.balEn = pwdata[11:0];
                OFS_MEASEN: n.cfg.measEn = pwdata[14:0];
                OFS_THR_SHORT: n.thrShort = pwdata[15:0]; // [R17]
                OFS_THR_LOW: n.thrLow = pwdata[15:0];
                OFS_THR_HIGH: n.thrHigh = pwdata[15:0];
                OFS_ALERTS: n.alerts = r.alerts & ~pwdata[2:0];
                default: n.cfg = r.cfg;
            endcase
        end
        // write-one-to-clear; a same-cycle hit wins over the clear
        if (swWr) begin
            n.swFlags = r.swFlags & ~pwdata[11:0];
        end
        n.swFlags = n.swFlags | swSet; // [R21] [R9]
        if (r.cfg.mode == MODE_OFF) begin
            n.alerts = n.alerts | limitHits;
        end
        // [R11] comparisons ignored while a switch check runs
        if (smp.valid && smp.self_check_result) begin
            n.pend = code;
        end
        if (acqDone) begin
            n.result = (smp.valid && smp.self_check_result) ? code : r.pend; // [R2]
        end
        // effective config derives from the stored user config, so leaving
        // a mode falls straight back to the user settings
        n.eff.balEn = n.cfg.balEn; // [R12]
        n.eff.measEn = n.cfg.measEn;
        n.eff.altPath = n.cfg.altPath;
        n.eff.bipolar = n.cfg.bipolar;
        n.eff.suppress = n.cfg.mode != MODE_OFF; // [R11]
        case (n.cfg.mode)
            MODE_SHORT: begin
                n.eff.balEn = BAL_OFF; // [R13]
                n.eff.measEn[14:12] = MEAS_NO_AUX;
                n.eff.altPath = 1'b1;
            end
            MODE_OPEN: begin
                n.eff.measEn = {MEAS_NO_AUX, n.cfg.balEn}; // [R15]
                n.eff.altPath = 1'b1;
                n.eff.bipolar = 1'b1;
            end
            MODE_ODD: begin
                n.eff.balEn = BAL_ODD; // [R19] [R8]
                n.eff.altPath = 1'b1;
            end
            MODE_EVEN: begin
                n.eff.balEn = BAL_EVEN; // [R19] [R8]
                n.eff.altPath = 1'b1;
            end
            default: n.eff.suppress = 1'b0;
        endcase
        n.eff.shortAmp = 1'b0;
        n.eff.skipChop = 1'b0;
        n.eff.adcDrive = DRV_NONE;
        case (n.cfg.checkSel)
            SEL_OFFSET: begin
                n.eff.shortAmp = diagPhase; // [R1]
                n.eff.skipChop = 1'b1; // [R4]
                n.eff.bipolar = 1'b1; // [R3]
            end
            SEL_ZERO: begin
                n.eff.adcDrive = DRV_NEG; // [R6]
                n.eff.bipolar = 1'b1;
            end
            SEL_FULL: begin
                n.eff.adcDrive = DRV_POS; // [R7]
                n.eff.bipolar = 1'b1;
            end
            default: n.eff.adcDrive = DRV_NONE;
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            r.cfg.measEn <= RST_MEASEN;
            r.cfg.balEn <= RST_BALEN;
            r.eff.measEn <= RST_MEASEN;
            r.eff.balEn <= RST_BALEN;
            r.thrShort <= RST_THR;
            r.thrLow <= RST_THR;
            r.thrHigh <= RST_THR;
            r.result <= RST_RESULT;
            r.pend <= RST_RESULT;
        end else begin
            r <= n;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign eff = r.eff;
    assign swAlert = r.swFlags;
    assign limitAlert = r.alerts;

    chk_offset_short: assert property (@(posedge mclk) disable iff (!nrst)
        (r.cfg.checkSel == SEL_OFFSET && !wr) ##1 diagPhase |=>
        r.eff.shortAmp) else $error("amplifier inputs not shorted"); // [R1]
    chk_result_load: assert property (@(posedge mclk) disable iff (!nrst)
        acqDone && !(smp.valid && smp.self_check_result) |=>
        r.result == $past(r.pend)) else $error("result not loaded"); // [R2]
    chk_offset_bipolar: assert property (@(posedge mclk) disable iff (!nrst)
        r.cfg.checkSel == SEL_OFFSET |-> r.eff.bipolar && r.eff.skipChop)
        else $error("offset check not bipolar or chopping"); // [R3] [R4]
    chk_result_align: assert property (@(posedge mclk) disable iff (!nrst)
        r.result[1:0] == 2'b00 && r.pend[1:0] == 2'b00)
        else $error("result low bits not zero"); // [R5]
    chk_zero_full: assert property (@(posedge mclk) disable iff (!nrst)
        r.cfg.checkSel inside {SEL_ZERO, SEL_FULL} |-> r.eff.bipolar &&
        r.eff.adcDrive == (r.cfg.checkSel == SEL_ZERO ? DRV_NEG : DRV_POS))
        else $error("scale check drive wrong"); // [R6] [R7]
    chk_short_config: assert property (@(posedge mclk) disable iff (!nrst)
        r.cfg.mode == MODE_SHORT |-> r.eff.balEn == BAL_OFF &&
        r.eff.measEn[14:12] == MEAS_NO_AUX && r.eff.altPath)
        else $error("short mode config wrong"); // [R13]
    chk_open_config: assert property (@(posedge mclk) disable iff (!nrst)
        r.cfg.mode == MODE_OPEN |-> r.eff.bipolar && r.eff.altPath &&
        r.eff.measEn[11:0] == r.cfg.balEn)
        else $error("open mode config wrong"); // [R15]
    chk_alert_quiet: assert property (@(posedge mclk) disable iff (!nrst)
        r.cfg.mode != MODE_OFF |=> (r.alerts & ~$past(r.alerts)) == 3'h0)
        else $error("limit alert set during switch check"); // [R11]
    chk_config_restore: assert property (@(posedge mclk) disable iff (!nrst)
        r.cfg.mode == MODE_OFF |-> r.eff.balEn == r.cfg.balEn &&
        r.eff.measEn == r.cfg.measEn && r.eff.altPath == r.cfg.altPath)
        else $error("config not restored"); // [R12]
    chk_short_flag: assert property (@(posedge mclk) disable iff (!nrst)
        smp.valid && !smp.self_check_result && smp.idx < 4'hC &&
        r.cfg.mode == MODE_SHORT && smp.data < r.thrShort |=>
        r.swFlags[$past(smp.idx)]) else $error("short not flagged"); // [R14]
    chk_flag_sticky: assert property (@(posedge mclk) disable iff (!nrst)
        !swWr |=> ($past(r.swFlags) & ~r.swFlags) == 12'h000)
        else $error("switch flag lost"); // [R21]
    chk_wire_switches: assert property (@(posedge mclk) disable iff (!nrst)
        r.cfg.mode == MODE_ODD |-> r.eff.balEn == BAL_ODD && r.eff.altPath)
        else $error("odd wire check switches wrong"); // [R19]
endmodule

// file: design/ads_pkg.sv
// shared constants and carrier types of the diagnostic sequencer
package ads_pkg;
    localparam int ADS_NCELL = 12;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BALEN = 8'h04;
    localparam logic [7:0] OFS_MEASEN = 8'h08;
    localparam logic [7:0] OFS_THR_SHORT = 8'h0C;
    localparam logic [7:0] OFS_THR_LOW = 8'h10;
    localparam logic [7:0] OFS_THR_HIGH = 8'h14;
    localparam logic [7:0] OFS_RESULT = 8'h18;
    localparam logic [7:0] OFS_SWFLAGS = 8'h1C;
    localparam logic [7:0] OFS_ALERTS = 8'h20;
    localparam logic [7:0] OFS_EFFCFG = 8'h24;
    // control register fields
    localparam int CTRL_SEL_LSB = 0;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_BIPOLAR = 8;
    localparam int CTRL_ALTPATH = 9;
    localparam int CTRL_START = 12;
    // effective config readback fields
    localparam int EFF_BIPOLAR = 12;
    localparam int EFF_ALTPATH = 13;
    localparam int EFF_MEAS_LSB = 16;
    // reset values
    localparam logic [11:0] RST_BALEN = 12'h000;
    localparam logic [14:0] RST_MEASEN = 15'h7FFF;
    localparam logic [15:0] RST_THR = 16'h0000;
    localparam logic [15:0] RST_RESULT = 16'h0000;
    // forced settings
    localparam logic [11:0] BAL_ODD = 12'h555;
    localparam logic [11:0] BAL_EVEN = 12'hAAA;
    localparam logic [11:0] BAL_OFF = 12'h000;
    localparam logic [2:0] MEAS_NO_AUX = 3'h0;

    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_OFFSET = 3'b011,
        SEL_ZERO = 3'b100,
        SEL_FULL = 3'b101
    } ads_sel_t;

    typedef enum logic [2:0] {
        MODE_OFF = 3'b000,
        MODE_SHORT = 3'b001,
        MODE_OPEN = 3'b010,
        MODE_ODD = 3'b101,
        MODE_EVEN = 3'b110
    } ads_mode_t;

    typedef enum logic [1:0] {
        DRV_NONE = 2'b00,
        DRV_NEG = 2'b01,
        DRV_POS = 2'b10
    } ads_drv_t;

    typedef struct packed {
        logic [2:0] checkSel;
        logic [2:0] mode;
        logic bipolar;
        logic altPath;
        logic [11:0] balEn;
        logic [14:0] measEn;
    } ads_cfg_t;

    typedef struct packed {
        logic [11:0] balEn;
        logic [14:0] measEn;
        logic altPath;
        logic bipolar;
        logic shortAmp;
        logic skipChop;
        ads_drv_t adcDrive;
        logic acqStart;
        logic suppress;
    } ads_eff_t;

    typedef struct packed {
        logic valid;
        logic self_check_result;
        logic [3:0] idx;
        logic [15:0] data;
    } ads_smp_t;
endpackage

// file: tb/ads_conv_model.sv
// converter and acquisition sequencer model on the far side of the block
`timescale 1ns/1ns
module ads_conv_model
    import ads_pkg::*;
(
    input wire logic mclk, // clock
    input wire logic nrst, // async reset, active low
    input wire ads_eff_t eff, // effective configuration
    input wire logic [15:0] cellV [12], // cell or switch voltages
    input wire logic [15:0] offsCode, // code seen with shorted inputs
    output ads_smp_t smp, // sample stream
    output logic diagPhase, // diagnostic portion
    output logic acqDone // acquisition finished pulse
);
    logic [15:0] d;
    initial begin
        smp = '0;
        diagPhase = 1'b0;
        acqDone = 1'b0;
    end
    // converts only after the host starts it
    always begin
        @(posedge mclk);
        if (nrst && eff.acqStart) begin
            for (int i = 0; i < 12; i++) begin
                smp <= '{1'b1, 1'b0, 4'(i), cellV[i]};
                @(posedge mclk);
            end
            // idle stream toggles so stale data is never mistaken
            smp <= '{1'b0, 1'b0, 4'hF, ~cellV[11]};
            diagPhase <= 1'b1;
            @(posedge mclk);
            @(posedge mclk);
            d = eff.shortAmp ? offsCode : 16'h1234;
            if (eff.adcDrive == DRV_NEG) d = 16'h0000;
            if (eff.adcDrive == DRV_POS) d = 16'hFFF0;
            smp <= '{1'b1, 1'b1, 4'h0, d};
            diagPhase <= 1'b0;
            @(posedge mclk);
            smp <= '{1'b0, 1'b0, 4'hF, ~d};
            acqDone <= 1'b1;
            @(posedge mclk);
            acqDone <= 1'b0;
        end
    end
endmodule

// file: tb/ads_self_check_result_seq_tb.sv
// self-checking bench of the diagnostic sequencer
`timescale 1ns/1ns
module ads_self_check_result_seq_tb
    import ads_pkg::*;
();
    logic mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, diagPhase, acqDone, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [2:0] limitHits = 3'h0, limitAlert;
    logic [11:0] swAlert;
    logic [15:0] cellV [12];
    logic [15:0] offsCode = 16'h2057;
    ads_smp_t smp;
    ads_eff_t eff;
    int numErrors = 0, checks = 0, cycles = 0;

    always #25 mclk = ~mclk;

    ads_self_check_result_seq i_dut (.mclk(mclk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .smp(smp), .diagPhase(diagPhase),
        .acqDone(acqDone), .limitHits(limitHits), .eff(eff),
        .swAlert(swAlert), .limitAlert(limitAlert));
    ads_conv_model i_conv (.mclk(mclk), .nrst(nrst), .eff(eff),
        .cellV(cellV), .offsCode(offsCode), .smp(smp),
        .diagPhase(diagPhase), .acqDone(acqDone));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, numErrors);
        if (numErrors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // hang guard, far above the few thousand cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 12000) begin
            numErrors++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            numErrors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // no wait count assumed; the hang guard ends a stuck transfer
        do begin
            @(posedge mclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a,
                         input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        chk(what, rd, exp);
    endtask

    task automatic acquire(input logic [31:0] c);
        wr(OFS_CTRL, c | (32'h1 << CTRL_START));
        while (acqDone !== 1'b1) begin
            @(posedge mclk);
        end
        @(posedge mclk);
        @(posedge mclk);
    endtask

    function automatic logic [31:0] ctl(input logic [2:0] s, m);
        ctl = (32'(m) << CTRL_MODE_LSB) | 32'(s);
    endfunction

    function automatic logic [31:0] effx(input logic [11:0] b,
        input logic [14:0] m, input logic bip, alt);
        effx = (32'(m) << EFF_MEAS_LSB) | (32'(alt) << EFF_ALTPATH)
            | (32'(bip) << EFF_BIPOLAR) | 32'(b);
    endfunction

    initial begin
        foreach (cellV[i]) cellV[i] = 16'h0900;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rdchk("measen", OFS_MEASEN, 32'h7FFF);
        rdchk("effcfg", OFS_EFFCFG, effx(12'h000, 15'h7FFF, 0, 0));
        xfer(8'h28, 1'b0, 32'h0);
        chk("slverr", 32'(err), 32'h1);
        wr(OFS_RESULT, 32'hFFFF);
        rdchk("result", OFS_RESULT, 32'h0);
        $display("test registers done");

        wr(OFS_CTRL, ctl(SEL_OFFSET, MODE_OFF));
        chk("bipolar", eff.bipolar, 32'h1);
        chk("skipchop", eff.skipChop, 32'h1);
        acquire(ctl(SEL_OFFSET, MODE_OFF));
        rdchk("offset", OFS_RESULT, 32'h2054);
        wr(OFS_CTRL, ctl(SEL_ZERO, MODE_OFF));
        rdchk("held", OFS_RESULT, 32'h2054);
        for (int k = 0; k < 2; k++) begin
            wr(OFS_CTRL, ctl(k ? SEL_FULL : SEL_ZERO, MODE_OFF));
            chk("bip", eff.bipolar, 32'h1);
            chk("drive", eff.adcDrive, k ? 32'h2 : 32'h1);
            acquire(ctl(k ? SEL_FULL : SEL_ZERO, MODE_OFF));
            rdchk("scale", OFS_RESULT, k ? 32'hFFF0 : 32'h0);
        end
        $display("test self checks done");

        wr(OFS_CTRL, 32'h0);
        limitHits <= 3'h7;
        @(posedge mclk);
        limitHits <= 3'h0;
        @(posedge mclk);
        @(posedge mclk);
        chk("alerts", limitAlert, 32'h7);
        wr(OFS_ALERTS, 32'h7);
        chk("alerts w1c", limitAlert, 32'h0);

        // threshold just under the weakest cell
        wr(OFS_BALEN, 32'h0F3);
        wr(OFS_THR_SHORT, 32'h0800);
        cellV[3] = 16'h0700;
        cellV[5] = 16'h0800;
        cellV[7] = 16'h07FF;
        wr(OFS_CTRL, ctl(SEL_NONE, MODE_SHORT));
        rdchk("short", OFS_EFFCFG, effx(0, 15'h0FFF, 0, 1));
        chk("suppress", eff.suppress, 32'h1);
        limitHits <= 3'h7;
        acquire(ctl(SEL_NONE, MODE_SHORT));
        limitHits <= 3'h0;
        chk("suppressed", limitAlert, 32'h0);
        chk("swalert", swAlert, 32'h088);
        wr(OFS_CTRL, 32'h0);
        rdchk("restore", OFS_EFFCFG, effx(12'h0F3, 15'h7FFF, 0, 0));
        rdchk("sticky", OFS_SWFLAGS, 32'h088);
        wr(OFS_SWFLAGS, 32'hFFF);
        rdchk("cleared", OFS_SWFLAGS, 32'h0);
        $display("test switch short done");

        wr(OFS_BALEN, 32'h0FF);
        wr(OFS_THR_LOW, 32'h0100);
        wr(OFS_THR_HIGH, 32'h0400);
        foreach (cellV[i]) cellV[i] = 16'h0200;
        cellV[0] = 16'h0050;
        cellV[1] = 16'h0500;
        cellV[2] = 16'h0100;
        cellV[3] = 16'h0400;
        cellV[8] = 16'h0050;
        wr(OFS_CTRL, ctl(SEL_NONE, MODE_OPEN));
        rdchk("open", OFS_EFFCFG, effx(12'h0FF, 15'h00FF, 1, 1));
        acquire(ctl(SEL_NONE, MODE_OPEN));
        rdchk("open flags", OFS_SWFLAGS, 32'h003);
        $display("test switch open done");

        cellV[0] = 16'h0200;
        cellV[1] = 16'h0200;
        cellV[8] = 16'h0200;
        cellV[9] = 16'h0600;
        for (int k = 0; k < 2; k++) begin
            wr(OFS_SWFLAGS, 32'hFFF);
            wr(OFS_CTRL, ctl(SEL_NONE, k ? MODE_EVEN : MODE_ODD));
            chk("wire bal", eff.balEn, k ? 32'hAAA : 32'h555);
            chk("wire alt", eff.altPath, 32'h1);
            repeat (2000) @(posedge mclk);
            acquire(ctl(SEL_NONE, k ? MODE_EVEN : MODE_ODD));
            rdchk("wire flags", OFS_SWFLAGS, 32'h200);
        end
        wr(OFS_CTRL, 32'h0);
        rdchk("back", OFS_EFFCFG, effx(12'h0FF, 15'h7FFF, 0, 0));
        $display("test sense wire done");
        wrap_up();
    end
endmodule
